// [mhp_defs.svh]
// register offsets, field positions, reset values and counts for the modem host pin block
// assumes inclusion by bare name from the design file and the properties file
`ifndef MHP_DEFS_SVH
`define MHP_DEFS_SVH

`define MHP_ADDR_W        8
`define MHP_PIN_CNT       5
`define MHP_OFF_PIN_MODE  8'h00
`define MHP_OFF_GP_DIR    8'h04
`define MHP_OFF_GP_OUT    8'h08
`define MHP_OFF_GP_IN     8'h0c
`define MHP_OFF_CTRL      8'h10
`define MHP_OFF_IRQ_STAT  8'h14
`define MHP_OFF_IRQ_MASK  8'h18
`define MHP_OFF_STATUS    8'h1c

`define MHP_RST_PIN_MODE  5'h00
`define MHP_RST_GP_DIR    5'h00
`define MHP_RST_GP_OUT    5'h00
`define MHP_RST_IRQ_MASK  5'h1f

`define MHP_CTRL_SLEEP    0
`define MHP_CTRL_FLOW     7
`define MHP_CLR_ALL_HI    7
`define MHP_CLR_ALL_LO    6

`define MHP_FIFO_LVL_W    5
`define MHP_FIFO_DEPTH    5'h10
`define MHP_CTS_HI_PCT    7'h46
`define MHP_CTS_LO_PCT    7'h1e
`define MHP_PCT_FULL      7'h64

`define MHP_RESP_OKAY     2'h0
`define MHP_RESP_SLVERR   2'h2

`endif

// [mhp_pkg.sv]
// types shared by the modem host pin block
// assumes the defs header sits in the same folder
package mhp_pkg;
  typedef enum logic {
    MHP_OFFLINE,
    MHP_ONLINE
  } mhp_mode_type;
endpackage : mhp_pkg

// [mhp_pin_functions.sv]
// modem host pin functions: five multi-function pins, serial data pins,
// clear-to-send pacing, sleep and interrupt logic behind an axi4-lite slave
// assumes one 50 MHz clock, synchronous inputs, and a modem datapath on the plain ports
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`include "mhp_defs.svh"
`timescale 1ns/1ps

module mhp_pin_functions (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite slave
  input  wire logic [`MHP_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [`MHP_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // multi-function pins, index 0 is pin one
  input  wire logic [`MHP_PIN_CNT-1:0]     gp_pin_i,
  output logic [`MHP_PIN_CNT-1:0]          gp_pin_o,
  output logic [`MHP_PIN_CNT-1:0]          gp_pin_oe,
  // serial pins
  output logic                             rxd_pin,
  input  wire logic                        txd_pin,
  output logic                             cts_n_pin,
  // modem datapath side
  input  wire logic                        rx_serial_in,
  output logic                             tx_serial_out,
  input  wire logic [`MHP_FIFO_LVL_W-1:0]  tx_fifo_level,
  input  wire logic                        ring_on_seg,
  input  wire logic                        carrier_present,
  input  wire logic                        rx_frame_end_flag,
  input  wire logic                        link_connect,
  input  wire logic                        link_drop,
  input  wire logic                        evt_carrier_lost,
  input  wire logic                        evt_wake_ring,
  input  wire logic                        evt_loop_lost,
  input  wire logic                        evt_v23_reversal,
  input  wire logic                        evt_intrusion,
  output logic                             escape_to_cmd,
  output logic                             modem_online,
  output logic                             sleep_mode,
  output logic                             irq
);

  // register state
  logic [`MHP_PIN_CNT-1:0]     pin_mode_q;
  logic [`MHP_PIN_CNT-1:0]     gp_dir_q;
  logic [`MHP_PIN_CNT-1:0]     gp_out_q;
  logic [`MHP_PIN_CNT-1:0]     irq_status_sreg_q;
  logic [`MHP_PIN_CNT-1:0]     irq_mask_q;
  logic                        flow_ctrl_mode_bit_q;
  logic                        sleep_q;
  mhp_pkg::mhp_mode_type       mode_q;
  mhp_pkg::mhp_mode_type       mode_d;
  // bus state
  logic                        aw_got_q;
  logic                        w_got_q;
  logic [`MHP_ADDR_W-1:0]      aw_addr_q;
  logic [31:0]                 w_data_q;
  logic [3:0]                  w_strb_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        rvalid_q;
  logic [31:0]                 rdata_q;
  logic [1:0]                  rresp_q;
  // pin side state
  logic                        esc_meta_q;
  logic                        esc_sync_q;
  logic                        esc_prev_q;
  logic                        txd_prev_q;
  logic                        cts_q;
  logic                        cts_d;
  logic                        rxd_q;
  logic                        txd_q;
  logic                        esc_pulse_q;

  // decode of one register offset, shared by the read and the write path
  function automatic logic [7:0] mhp_decode(input logic [`MHP_ADDR_W-1:0] addr);
    logic [7:0] hit;
    hit    = 8'h00;
    hit[0] = (addr == `MHP_OFF_PIN_MODE);
    hit[1] = (addr == `MHP_OFF_GP_DIR);
    hit[2] = (addr == `MHP_OFF_GP_OUT);
    hit[3] = (addr == `MHP_OFF_GP_IN);
    hit[4] = (addr == `MHP_OFF_CTRL);
    hit[5] = (addr == `MHP_OFF_IRQ_STAT);
    hit[6] = (addr == `MHP_OFF_IRQ_MASK);
    hit[7] = (addr == `MHP_OFF_STATUS);
    return hit;
  endfunction : mhp_decode

  // write path: address and data are taken in either order, then applied together
  wire [7:0]  wr_hit  = mhp_decode(aw_addr_q);
  wire        wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  wire        wr_lane = wr_fire & w_strb_q[0];
  wire [7:0]  wr_byte = w_data_q[7:0];
  wire [7:0]  rd_hit  = mhp_decode(s_axi_araddr);
  wire        ar_take = s_axi_arvalid & ~rvalid_q;

  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // interrupt events count only while a connection stands
  wire [`MHP_PIN_CNT-1:0] evt_vec = {evt_intrusion, evt_v23_reversal, evt_loop_lost,
                                     evt_wake_ring, evt_carrier_lost};
  wire                    connected = (mode_q == mhp_pkg::MHP_ONLINE);
  wire [`MHP_PIN_CNT-1:0] irq_set   = evt_vec & {`MHP_PIN_CNT{connected}};
  // a one in bit seven or six clears every bit; bits four to zero clear their own bit
  wire                    clr_all   = wr_byte[`MHP_CLR_ALL_HI] | wr_byte[`MHP_CLR_ALL_LO];
  wire [`MHP_PIN_CNT-1:0] irq_clr   = (wr_lane & wr_hit[5]) ?
                                      (wr_byte[`MHP_PIN_CNT-1:0] | {`MHP_PIN_CNT{clr_all}}) :
                                      {`MHP_PIN_CNT{1'b0}};
  // set wins over a clear landing in the same cycle, so no event is lost
  wire [`MHP_PIN_CNT-1:0] irq_stat_d = (irq_status_sreg_q & ~irq_clr) | irq_set;
  wire                    irq_level  = |(irq_status_sreg_q & irq_mask_q);

  // read mux, unused high bits read as zero
  wire [7:0] status_byte = {3'h0, cts_q, sleep_q, connected, 2'h0};
  wire [7:0] ctrl_byte   = {flow_ctrl_mode_bit_q, 6'h00, sleep_q};
  wire [7:0] rd_byte =
    ({8{rd_hit[0]}} & {3'h0, pin_mode_q}) |
    ({8{rd_hit[1]}} & {3'h0, gp_dir_q}) |
    ({8{rd_hit[2]}} & {3'h0, gp_out_q}) |
    ({8{rd_hit[3]}} & {3'h0, gp_pin_i}) |
    ({8{rd_hit[4]}} & ctrl_byte) |
    ({8{rd_hit[5]}} & {3'h0, irq_status_sreg_q}) |
    ({8{rd_hit[6]}} & {3'h0, irq_mask_q}) |
    ({8{rd_hit[7]}} & status_byte);
  wire       rd_ok = |rd_hit;

  // bus handshake flags and responses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_addr_q <= {`MHP_ADDR_W{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `MHP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (|wr_hit) ? `MHP_RESP_OKAY : `MHP_RESP_SLVERR;
      end
      else if (bvalid_q & s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `MHP_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_ok ? `MHP_RESP_OKAY : `MHP_RESP_SLVERR;
    end
    else if (rvalid_q & s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // control registers; only byte lane zero carries bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_mode_q           <= `MHP_RST_PIN_MODE;
      gp_dir_q             <= `MHP_RST_GP_DIR;
      gp_out_q             <= `MHP_RST_GP_OUT;
      irq_mask_q           <= `MHP_RST_IRQ_MASK;
      irq_status_sreg_q    <= {`MHP_PIN_CNT{1'b0}};
      flow_ctrl_mode_bit_q <= 1'b0;
      sleep_q              <= 1'b0;
    end
    else
    begin
      irq_status_sreg_q <= irq_stat_d;
      if (wr_lane & wr_hit[0])
        pin_mode_q <= wr_byte[`MHP_PIN_CNT-1:0];
      if (wr_lane & wr_hit[1])
        gp_dir_q <= wr_byte[`MHP_PIN_CNT-1:0];
      if (wr_lane & wr_hit[2])
        gp_out_q <= wr_byte[`MHP_PIN_CNT-1:0];
      if (wr_lane & wr_hit[6])
        irq_mask_q <= wr_byte[`MHP_PIN_CNT-1:0];
      if (wr_lane & wr_hit[4])
      begin
        flow_ctrl_mode_bit_q <= wr_byte[`MHP_CTRL_FLOW];
        sleep_q              <= wr_byte[`MHP_CTRL_SLEEP];
      end
    end
  end

  // escape synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      esc_meta_q <= 1'b0;
      esc_sync_q <= 1'b0;
      esc_prev_q <= 1'b0;
    end
    else
    begin
      esc_meta_q <= gp_pin_i[2];
      esc_sync_q <= esc_meta_q;
      esc_prev_q <= esc_sync_q;
    end
  end

  wire escape_edge_input = pin_mode_q[2] & esc_sync_q & ~esc_prev_q;
  // an edge while offline falls through the case without effect
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      mhp_pkg::MHP_OFFLINE:
        if (link_connect)
          mode_d = mhp_pkg::MHP_ONLINE;
      mhp_pkg::MHP_ONLINE:
        if (escape_edge_input | link_drop)
          mode_d = mhp_pkg::MHP_OFFLINE;
      default:
        mode_d = mhp_pkg::MHP_OFFLINE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q      <= mhp_pkg::MHP_OFFLINE;
      esc_pulse_q <= 1'b0;
    end
    else
    begin
      mode_q      <= mode_d;
      esc_pulse_q <= escape_edge_input & connected;
    end
  end

  // clear-to-send pacing; levels compared in percent to avoid rounding of thresholds
  wire [11:0] lvl_pct  = 12'(tx_fifo_level) * 12'(`MHP_PCT_FULL);
  wire [11:0] hi_mark  = 12'(`MHP_FIFO_DEPTH) * 12'(`MHP_CTS_HI_PCT);
  wire [11:0] lo_mark  = 12'(`MHP_FIFO_DEPTH) * 12'(`MHP_CTS_LO_PCT);
  wire        start_bit = txd_prev_q & ~txd_pin;
  wire        fifo_empty = (tx_fifo_level == {`MHP_FIFO_LVL_W{1'b0}});
  always_comb
  begin
    cts_d = cts_q;
    if (!flow_ctrl_mode_bit_q)
    begin
      if (start_bit)
        cts_d = 1'b0;
      else if (fifo_empty)
        cts_d = 1'b1;
    end
    else
    begin
      if (lvl_pct >= hi_mark)
        cts_d = 1'b0;
      else if (lvl_pct <= lo_mark)
        cts_d = 1'b1;
    end
  end

  // serial data retimed by one flop each way
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cts_q      <= 1'b1;
      txd_prev_q <= 1'b1;
      rxd_q      <= 1'b1;
      txd_q      <= 1'b1;
    end
    else
    begin
      cts_q      <= cts_d;
      txd_prev_q <= txd_pin;
      rxd_q      <= rx_serial_in;
      txd_q      <= txd_pin;
    end
  end

  // alternate functions per pin: frame end, carrier, escape input, interrupt, ring
  wire [`MHP_PIN_CNT-1:0] alt_out = {~ring_on_seg, irq_level, 1'b0,
                                     ~carrier_present, rx_frame_end_flag};
  wire [`MHP_PIN_CNT-1:0] alt_oe  = 5'h1b; // pin three stays an input for escape

  genvar gi;
  generate
    for (gi = 0; gi < `MHP_PIN_CNT; gi++)
    begin : g_pin
      // general-purpose mode follows the direction and value registers
      assign gp_pin_o[gi]  = pin_mode_q[gi] ? alt_out[gi] : gp_out_q[gi];
      assign gp_pin_oe[gi] = pin_mode_q[gi] ? alt_oe[gi] : gp_dir_q[gi];
    end
  endgenerate

  assign rxd_pin       = rxd_q;
  assign tx_serial_out = txd_q;
  assign cts_n_pin     = ~cts_q;
  assign escape_to_cmd = esc_pulse_q;
  assign modem_online  = connected;
  assign sleep_mode    = sleep_q;
  assign irq           = irq_level;

endmodule : mhp_pin_functions

// [mhp_pin_functions_properties.sv]
// timing relations on the ports of the modem host pin block
// assumes a bind onto the top module and its single clock domain
`include "mhp_defs.svh"
`timescale 1ns/1ps
module mhp_pin_functions_properties (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic [`MHP_PIN_CNT-1:0]   gp_pin_i,
  input wire logic [`MHP_PIN_CNT-1:0]   gp_pin_oe,
  input wire logic                      rxd_pin,
  input wire logic                      rx_serial_in,
  input wire logic                      txd_pin,
  input wire logic                      tx_serial_out,
  input wire logic                      cts_n_pin,
  input wire logic [`MHP_FIFO_LVL_W-1:0] tx_fifo_level,
  input wire logic                      escape_to_cmd,
  input wire logic                      modem_online,
  input wire logic                      sleep_mode,
  input wire logic                      irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // escape rise reaches the mode logic through two sync flops and an edge flop
  sequence esc_rise_s;
    $past(gp_pin_i[2], 3) && !$past(gp_pin_i[2], 4);
  endsequence
  sequence both_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  chk_reset_state: assert property (
    $rose(aresetn) |-> gp_pin_oe == 5'h00 && !cts_n_pin && !sleep_mode && !modem_online && !irq)
    else $error("outputs not at reset state");
  chk_escape_timing: assert property (
    escape_to_cmd |-> esc_rise_s)
    else $error("escape pulse without synced rise");
  chk_escape_offline: assert property (
    escape_to_cmd |-> !modem_online && $past(modem_online))
    else $error("escape pulse without online to offline");
  chk_cts_negate: assert property (
    $rose(cts_n_pin) |-> ($past(txd_pin, 2) && !$past(txd_pin)) || $past(tx_fifo_level) >= 5'h0c)
    else $error("clear-to-send negated without cause");
  chk_cts_release: assert property (
    $fell(cts_n_pin) |-> $past(tx_fifo_level) <= 5'h04)
    else $error("clear-to-send reasserted above low mark");
  chk_irq_hold: assert property (
    $fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a register write");
  chk_serial_copy: assert property (
    $past(aresetn) |-> rxd_pin == $past(rx_serial_in) && tx_serial_out == $past(txd_pin))
    else $error("serial data not passed through");
  chk_write_resp: assert property (
    both_taken_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule : mhp_pin_functions_properties

// [mhp_host_model.sv]
// host side of the serial pins: sends one character when asked
// assumes one bit every BIT_CYC clocks and a line idling high
`timescale 1ns/1ps
module mhp_host_model #(
  parameter int BIT_CYC = 4
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       cts_n_pin,
  input  wire logic       go,
  input  wire logic [7:0] data,
  output logic            txd_pin,
  output logic            busy
);
  logic [9:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] cnt_q;

  // line idles at mark so no stale start bit leaks out
  assign busy    = bit_q != 4'h0;
  assign txd_pin = busy ? sh_q[0] : 1'b1;

  // a character once begun runs to its stop bit, as a real uart does
  always_ff @(posedge aclk)
    if (!aresetn)
      bit_q <= 4'h0;
    else if (!busy && go && !cts_n_pin)
    begin
      sh_q  <= {1'b1, data, 1'b0};
      bit_q <= 4'ha;
      cnt_q <= 8'h00;
    end
    else if (busy && cnt_q == 8'(BIT_CYC - 1))
    begin
      sh_q  <= {1'b1, sh_q[9:1]};
      bit_q <= bit_q - 4'h1;
      cnt_q <= 8'h00;
    end
    else if (busy)
      cnt_q <= cnt_q + 8'h01;
endmodule : mhp_host_model

// [tb_top.sv]
// self-checking bench for the modem host pin block
// assumes the design, its checker and the host model compiled before it
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d, e; logic [1:0] r;} mhp_row_type;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, txd_pin, rx_serial_in, ring_on_seg, carrier_present, go, busy;
  logic        rx_frame_end_flag, link_connect, link_drop, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxd_pin, cts_n_pin, tx_serial_out;
  logic        escape_to_cmd, modem_online, sleep_mode, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  gp_pin_i, gp_pin_o, gp_pin_oe, tx_fifo_level, ev;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int          bad_count, check_count, i, n;
  wire         evt_carrier_lost = ev[0], evt_wake_ring = ev[1], evt_loop_lost = ev[2];
  wire         evt_v23_reversal = ev[3], evt_intrusion = ev[4];
  // reset reads, then write and read back, an unmapped place and the input port
  mhp_row_type rows [14] = '{'{8'h00,1'b0,32'h0,32'h0,2'h0}, '{8'h04,1'b0,32'h0,32'h0,2'h0},
    '{8'h08,1'b0,32'h0,32'h0,2'h0}, '{8'h10,1'b0,32'h0,32'h0,2'h0},
    '{8'h14,1'b0,32'h0,32'h0,2'h0}, '{8'h18,1'b0,32'h0,32'h1f,2'h0},
    '{8'h1c,1'b0,32'h0,32'h10,2'h0}, '{8'h04,1'b1,32'hff,32'h1f,2'h0},
    '{8'h08,1'b1,32'h15,32'h15,2'h0}, '{8'h10,1'b1,32'h81,32'h81,2'h0},
    '{8'h1c,1'b0,32'h0,32'h18,2'h0}, '{8'h18,1'b1,32'h0,32'h0,2'h0},
    '{8'h20,1'b1,32'h5,32'h0,2'h2}, '{8'h0c,1'b0,32'h0,32'h0a,2'h0}};
  logic [4:0]  lv [6] = '{5'h0c, 5'h05, 5'h04, 5'h0b, 5'h0c, 5'h03};
  logic [5:0]  lv_exp = 6'b110010;

  mhp_pin_functions dut_u (.*);
  mhp_host_model host_u (.aclk(aclk), .aresetn(aresetn), .cts_n_pin(cts_n_pin), .go(go),
    .data(8'h5a), .txd_pin(txd_pin), .busy(busy));

  // 50 MHz system clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // one bit wider than a data word so a flag can ride above the read value
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  // each channel held until its ready is seen at an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rdr

  task automatic pulse_ev(input logic [4:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 5'h00;
  endtask : pulse_ev

  // let edge updates land before looking
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic results;
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    results();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {link_connect, link_drop, go, ev, tx_fifo_level, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {rx_serial_in, ring_on_seg, carrier_present, rx_frame_end_flag} = 4'hf;
    s_axi_wstrb = 4'hf;
    gp_pin_i = 5'h0a;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[k])
    begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      if (rows[k].w) chk(rsp, rows[k].r);
      rdr(rows[k].a);
      chk(rd, rows[k].e);
      chk(rsp, rows[k].r);
    end
    settle(0);
    chk({sleep_mode, gp_pin_oe, gp_pin_o}, 11'h7f5);
    wr(8'h00, 32'h1f);
    settle(0);
    chk({gp_pin_oe, gp_pin_o & 5'h1b}, 10'h361);
    @(posedge aclk);
    {ring_on_seg, carrier_present, rx_frame_end_flag} <= 3'h0;
    settle(0);
    chk(gp_pin_o & 5'h1b, 5'h12);
    pulse_ev(5'h01);
    rdr(8'h14);
    chk(rd, 32'h0);
    @(posedge aclk);
    link_connect <= 1'b1;
    @(posedge aclk);
    link_connect <= 1'b0;
    for (i = 0; i < 5; i++) pulse_ev(5'(1 << i));
    rdr(8'h14);
    chk({irq, rd}, 33'h1f);
    wr(8'h18, 32'h1f);
    settle(5);
    chk({irq, gp_pin_o[3]}, 2'h3);
    wr(8'h14, 32'h01);
    rdr(8'h14);
    chk({irq, rd}, 33'h1_0000_001e);
    wr(8'h14, 32'h40);
    rdr(8'h14);
    chk({irq, rd}, 33'h0);
    gp_pin_i[2] <= 1'b1;
    for (n = 0; n < 8 && escape_to_cmd !== 1'b1; n++) @(posedge aclk);
    chk({escape_to_cmd, modem_online}, 2'h2);
    gp_pin_i[2] <= 1'b0;
    repeat (3) @(posedge aclk);
    gp_pin_i[2] <= 1'b1;
    n = 0;
    for (i = 0; i < 10; i++) @(posedge aclk) if (escape_to_cmd) n++;
    chk(n, 0);
    pulse_ev(5'h10);
    rdr(8'h14);
    chk(rd, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      @(posedge aclk);
      tx_fifo_level <= lv[i];
      settle(2);
      chk(cts_n_pin, lv_exp[5 - i]);
    end
    wr(8'h10, 32'h00);
    @(posedge aclk);
    go <= 1'b1;
    rx_serial_in <= 1'b0;
    while (!busy) @(posedge aclk);
    go <= 1'b0;
    settle(2);
    chk({cts_n_pin, tx_serial_out, rxd_pin}, 3'h4);
    while (busy) @(posedge aclk);
    chk(cts_n_pin, 1'b1);
    tx_fifo_level <= 5'h00;
    settle(2);
    chk(cts_n_pin, 1'b0);
    @(posedge aclk);
    link_connect <= 1'b1;
    @(posedge aclk);
    link_connect <= 1'b0;
    pulse_ev(5'h04);
    wr(8'h10, 32'h01);
    settle(0);
    chk({irq, sleep_mode, modem_online}, 3'h7);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    chk({irq, sleep_mode, modem_online, cts_n_pin, gp_pin_oe}, 9'h0);
    rdr(8'h00);
    chk(rd, 32'h0);
    results();
  end
endmodule : tb_top

bind mhp_pin_functions mhp_pin_functions_properties chk_u (.*);
